// ==== pkg/bd_pkg.sv ====
package bd_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int DIV_W = 17;
  localparam int TW = 9;
  typedef logic [DIV_W-1:0] div_type;
  typedef logic [TW-1:0] time_type;
  localparam int PRESS_MIN_MS = 100;
  localparam int PRESS_MAX_MS = 5000;
  localparam int GAP_MAX_MS = 2000;
  localparam int RESP_MS = 3500;
  localparam int BLINK_MS = 500;
  localparam int DIGIT_MS = 1500;
  localparam int MSG_MS = 2500;
  localparam int FINAL_MS = 5000;
  localparam time_type PRESS_MIN_T = time_type'((PRESS_MIN_MS + TICK_MS - 1) / TICK_MS);
  localparam time_type PRESS_MAX_T = time_type'(PRESS_MAX_MS / TICK_MS);
  localparam time_type GAP_T = time_type'(GAP_MAX_MS / TICK_MS);
  localparam time_type RESP_T = time_type'(RESP_MS / TICK_MS);
  localparam time_type BLINK_T = time_type'(BLINK_MS / TICK_MS);
  localparam time_type DIGIT_T = time_type'(DIGIT_MS / TICK_MS);
  localparam time_type MSG_T = time_type'(MSG_MS / TICK_MS);
  localparam time_type FINAL_T = time_type'(FINAL_MS / TICK_MS);
  localparam int N_ACT = 8;
  localparam int N_HIST = 16;
  localparam logic [2:0] CFG_LAST = 3'h5;
  localparam logic [2:0] MSG_LAST = 3'h1;
  localparam logic [3:0] PRESS_ACTIVE = 4'h1;
  localparam logic [3:0] PRESS_HIST = 4'h2;
  localparam logic [3:0] PRESS_CLEAR = 4'h3;
  localparam logic [3:0] PRESS_CONFIG = 4'h4;
  localparam logic [3:0] PRESS_TEST = 4'h5;
  localparam logic [3:0] PRESS_RECONF = 4'h7;
  localparam logic [3:0] PRESS_LEAVE = 4'h3;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h08;
  localparam logic [7:0] ADDR_NOTE = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_HIST = 8'h14;
  localparam int CTRL_TEST = 0;
  localparam int CTRL_CLR_ACT = 1;
  localparam int CTRL_CLR_HIST = 2;
  localparam int FAULT_WSS = 8;
  localparam int CFG_24V = 0;
  localparam int CFG_SIX = 1;
  localparam int CFG_MOD = 2;
  localparam int CFG_ENG = 4;
  localparam int CFG_BRK = 5;
  localparam int CFG_J1939 = 6;
  localparam int CFG_RELAY = 7;
  localparam logic [3:0] SUPPLY_12V = 4'h1;
  localparam logic [3:0] SUPPLY_24V = 4'h2;
  localparam logic [3:0] SENS_4 = 4'h4;
  localparam logic [3:0] SENS_6 = 4'h6;
  localparam logic [3:0] MOD_BASE = 4'h4;
  localparam logic [3:0] MOD_MAX = 4'h6;
  localparam logic [3:0] ABS_EQ = 4'h1;
  localparam logic [3:0] ABS_6S4M = 4'h2;
  localparam logic [3:0] ABS_6S5M = 4'h3;
  localparam logic [3:0] SPIN_BASE = 4'h2;
  localparam logic [3:0] RET_BASE = 4'h1;
  localparam logic [7:0] SWITCH_NOTE = 8'hF1;
  typedef enum logic [2:0] {IDLE = 3'b000, COUNT = 3'b001, BLINK = 3'b010, TEST = 3'b011} state_type;
  typedef enum logic [1:0] {SRC_ACTIVE = 2'b00, SRC_HIST = 2'b01, SRC_CONFIG = 2'b10} src_type;
  typedef enum logic [1:0] {PH_ON = 2'b00, PH_GAP = 2'b01, PH_FINAL = 2'b10} phase_type;
  typedef struct packed {logic valid; logic wss; logic [7:0] code;} fault_type;
  typedef struct packed {logic note; logic [7:0] code;} hist_type;
  typedef struct packed {logic psel; logic penable; logic pwrite; logic [7:0] paddr; logic [31:0] pwdata;} apb_req_type;
  typedef struct packed {logic [31:0] prdata; logic pready; logic pslverr;} apb_rsp_type;
  typedef struct packed {
    state_type st; src_type src; phase_type ph;
    logic [2:0] sync; logic swLevel; logic prevLevel; div_type divCnt; logic tick;
    time_type holdT; time_type gapT; time_type blT; time_type gapLim; logic [3:0] presses;
    logic started; logic armChecked; logic armed; logic ignoreHold; logic inTest;
    logic [3:0] blinkLeft; logic [3:0] msgIdx; logic [2:0] digSel;
    fault_type [N_ACT-1:0] act; hist_type [N_HIST-1:0] hist; logic [4:0] histCnt;
    logic wssHold; logic testStand; logic switchFault; logic reconfigReq; logic reconfigStart;
    logic [7:0] setup; logic [3:0] histIdx; logic lamp; logic spinEn; logic [7:0] wssOut;
    logic [31:0] rdata; logic slvErr;
  } regs_type;
  localparam regs_type RESET_REGS = '0;
endpackage

// ==== core/blink_code_diag.sv ====
// Overview of operation
// - one press shows active fault codes
// - two presses show stored inactive codes
// - three presses clear all active faults
// - four presses show configuration report
// - five presses enter test stand, spin off
// - held at power-up, then seven presses reconfigures
// - power cycle clears non-sensor active faults
// - sensor faults stay until speed valid or a clear
// - cleared active faults go to history
// - history also holds event notes
// - configuration report is six fixed digits
// - digit one gives supply voltage
// - digits two to four give sensors, modulators
// - digit five gives wheel-spin control setup
// - digit six gives retarder setup
// - test stand persists, tool alone clears it
// - three presses in test stand return to idle, stand flag kept
// - tool clear drops sensor faults at once
// - tool reads and erases history
// - press counts between 0.1 and 5 seconds
// - gaps under 2 s, answer after 3.5 s
// - lamp blink, digit, message, final timing
// - vehicle motion blocks or ends blink mode
module blink_code_diag #(
  parameter int TICK_CYCLES = bd_pkg::TICK_CYCLES
) (
  // clock and ignition reset
  input  logic                sys_clk,
  input  logic                reset,
  // switch, wheel state, retained settings
  input  logic                blinkSwitch,
  input  logic                vehicleMoving,
  input  logic                wheelSpeedValid,
  input  logic                storedTestStand,
  input  logic [7:0]          retainedWss,
  // lamp and controls
  output logic                lamp,
  output logic                wheelSpinEnable,
  output logic                testStandMode,
  output logic [7:0]          retainedWssOut,
  output logic                reconfigStart,
  // register bus
  input  bd_pkg::apb_req_type apbReq,
  output bd_pkg::apb_rsp_type apbRsp
);
  bd_pkg::regs_type s;
  bd_pkg::regs_type next_s;
  logic             press;
  logic             apbWr;
  logic [4:0]       found;
  logic [7:0]       freeSlots;

  function automatic bd_pkg::regs_type histPush(bd_pkg::regs_type r, logic note, logic [7:0] code);
    if (r.histCnt < 5'(bd_pkg::N_HIST)) begin
      r.hist[r.histCnt[3:0]] = {note, code};
      r.histCnt = r.histCnt + 5'h01;
    end
    return r;
  endfunction

  function automatic bd_pkg::regs_type clearAll(bd_pkg::regs_type r);
    for (int i = 0; i < bd_pkg::N_ACT; i++) begin
      if (r.act[i].valid) begin
        r = histPush(r, 1'b0, r.act[i].code);
        r.act[i].valid = 1'b0;
      end
    end
    r.wssHold = 1'b0;
    return r;
  endfunction

  // lowest set bit at or above the start index, with a found flag
  function automatic logic [4:0] nextFrom(logic [15:0] mask, logic [4:0] from);
    logic [4:0] res;
    res = '0;
    for (int i = bd_pkg::N_HIST - 1; i >= 0; i--) begin
      if (mask[i] && 5'(i) >= from) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction

  function automatic logic [15:0] msgMask(bd_pkg::regs_type r);
    logic [15:0] m;
    m = '0;
    for (int i = 0; i < bd_pkg::N_ACT; i++) begin
      m[i] = (r.src == bd_pkg::SRC_ACTIVE) && r.act[i].valid;
    end
    for (int i = 0; i < bd_pkg::N_HIST; i++) begin
      if (r.src == bd_pkg::SRC_HIST) begin
        m[i] = 5'(i) < r.histCnt && !r.hist[i].note;
      end
    end
    return m;
  endfunction

  function automatic logic [3:0] cfgDigit(logic [7:0] c, logic [2:0] sel);
    logic [3:0] mods;
    logic [3:0] d;
    mods = (c[bd_pkg::CFG_MOD+:2] == 2'b11) ? bd_pkg::MOD_MAX : bd_pkg::MOD_BASE + {2'b00, c[bd_pkg::CFG_MOD+:2]};
    case (sel)
      3'h0: d = c[bd_pkg::CFG_24V] ? bd_pkg::SUPPLY_24V : bd_pkg::SUPPLY_12V;
      3'h1: d = c[bd_pkg::CFG_SIX] ? bd_pkg::SENS_6 : bd_pkg::SENS_4;
      3'h2: d = mods;
      3'h3: begin
        d = bd_pkg::ABS_EQ;
        if (c[bd_pkg::CFG_SIX] && mods == bd_pkg::MOD_BASE) d = bd_pkg::ABS_6S4M;
        if (c[bd_pkg::CFG_SIX] && mods == bd_pkg::MOD_BASE + 4'h1) d = bd_pkg::ABS_6S5M;
      end
      3'h4: d = bd_pkg::SPIN_BASE + {3'b000, c[bd_pkg::CFG_ENG]} + {2'b00, c[bd_pkg::CFG_BRK], 1'b0};
      default: d = bd_pkg::RET_BASE + {3'b000, c[bd_pkg::CFG_J1939]} + {2'b00, c[bd_pkg::CFG_RELAY], 1'b0};
    endcase
    return d;
  endfunction

  function automatic logic lastDigit(bd_pkg::regs_type r);
    return r.digSel == ((r.src == bd_pkg::SRC_CONFIG) ? bd_pkg::CFG_LAST : bd_pkg::MSG_LAST);
  endfunction

  // a zero digit still gives one blink so the sequence never stalls
  function automatic bd_pkg::regs_type loadDigit(bd_pkg::regs_type r);
    logic [7:0] code;
    logic [3:0] d;
    code = (r.src == bd_pkg::SRC_ACTIVE) ? r.act[r.msgIdx[2:0]].code : r.hist[r.msgIdx].code;
    d = (r.digSel == 3'h0) ? code[7:4] : code[3:0];
    if (r.src == bd_pkg::SRC_CONFIG) d = cfgDigit(r.setup, r.digSel);
    r.blinkLeft = (d == 4'h0) ? 4'h1 : d;
    r.ph = bd_pkg::PH_ON;
    r.blT = '0;
    r.lamp = 1'b1;
    return r;
  endfunction

  function automatic bd_pkg::regs_type startBlink(bd_pkg::regs_type r, bd_pkg::src_type src);
    logic [4:0] f;
    r.st = bd_pkg::BLINK;
    r.src = src;
    r.digSel = '0;
    r.msgIdx = '0;
    f = nextFrom(msgMask(r), 5'h00);
    if (src == bd_pkg::SRC_CONFIG) begin
      r = loadDigit(r);
    end else if (f[4]) begin
      r.msgIdx = f[3:0];
      r = loadDigit(r);
    end else begin
      r.ph = bd_pkg::PH_FINAL;
      r.blT = '0;
      r.lamp = 1'b1;
    end
    return r;
  endfunction

  function automatic bd_pkg::regs_type dispatch(bd_pkg::regs_type r);
    r.st = bd_pkg::IDLE;
    if (r.inTest) begin
      r.inTest = 1'b0;
      if (r.presses != bd_pkg::PRESS_LEAVE) r.st = bd_pkg::TEST;
    end else begin
      case (r.presses)
        bd_pkg::PRESS_ACTIVE: r = startBlink(r, bd_pkg::SRC_ACTIVE);
        bd_pkg::PRESS_HIST: r = startBlink(r, bd_pkg::SRC_HIST);
        bd_pkg::PRESS_CLEAR: r = clearAll(r);
        bd_pkg::PRESS_CONFIG: r = startBlink(r, bd_pkg::SRC_CONFIG);
        bd_pkg::PRESS_TEST: begin
          r.testStand = 1'b1;
          r.st = bd_pkg::TEST;
        end
        bd_pkg::PRESS_RECONF: begin
          r.reconfigStart = r.armed;
          r.reconfigReq = r.reconfigReq | r.armed;
        end
        default: r.st = bd_pkg::IDLE;
      endcase
    end
    r.armed = 1'b0;
    return r;
  endfunction

  assign apbWr = apbReq.psel && apbReq.penable && apbReq.pwrite;

  always_comb begin
    found = '0;
    freeSlots = '0;
    press = 1'b0;
    next_s = s;
    next_s.reconfigStart = 1'b0;
    next_s.sync = {s.sync[1:0], blinkSwitch};
    if (s.sync[1] == s.sync[2]) next_s.swLevel = s.sync[2];
    next_s.prevLevel = s.swLevel;
    next_s.tick = 1'b0;
    next_s.divCnt = s.divCnt + 1'b1;
    if (s.divCnt == bd_pkg::div_type'(TICK_CYCLES - 1)) begin
      next_s.divCnt = '0;
      next_s.tick = 1'b1;
    end
    // retained settings are caught on the first clock after release
    if (!s.started) begin
      next_s.started = 1'b1;
      next_s.testStand = storedTestStand;
      if (storedTestStand) next_s.st = bd_pkg::TEST;
      if (retainedWss != 8'h00) begin
        next_s.act[0] = {1'b1, 1'b1, retainedWss};
        next_s.wssHold = 1'b1;
      end
    end
    if (apbWr) begin
      if (apbReq.paddr == bd_pkg::ADDR_CTRL) begin
        next_s.testStand = apbReq.pwdata[bd_pkg::CTRL_TEST];
        if (apbReq.pwdata[bd_pkg::CTRL_CLR_HIST]) next_s.histCnt = '0;
        if (apbReq.pwdata[bd_pkg::CTRL_CLR_ACT]) next_s = clearAll(next_s);
      end else if (apbReq.paddr == bd_pkg::ADDR_CONFIG) begin
        next_s.setup = apbReq.pwdata[7:0];
      end else if (apbReq.paddr == bd_pkg::ADDR_FAULT) begin
        for (int i = 0; i < bd_pkg::N_ACT; i++) freeSlots[i] = !s.act[i].valid;
        found = nextFrom({8'h00, freeSlots}, 5'h00);
        if (found[4]) next_s.act[found[2:0]] = {1'b1, apbReq.pwdata[bd_pkg::FAULT_WSS], apbReq.pwdata[7:0]};
      end else if (apbReq.paddr == bd_pkg::ADDR_NOTE) begin
        next_s = histPush(next_s, 1'b1, apbReq.pwdata[7:0]);
      end else if (apbReq.paddr == bd_pkg::ADDR_HIST) begin
        next_s.histIdx = apbReq.pwdata[3:0];
      end
    end
    if (s.tick && !s.armChecked) begin
      next_s.armChecked = 1'b1;
      if (s.swLevel) begin
        next_s.armed = 1'b1;
        next_s.ignoreHold = 1'b1;
      end
    end
    if (s.tick && s.swLevel && s.holdT < bd_pkg::PRESS_MAX_T) begin
      next_s.holdT = s.holdT + 1'b1;
      if (next_s.holdT == bd_pkg::PRESS_MAX_T && !s.ignoreHold) begin
        next_s.switchFault = 1'b1;
        next_s = histPush(next_s, 1'b1, bd_pkg::SWITCH_NOTE);
      end
    end
    if (s.prevLevel && !s.swLevel) begin
      press = !s.ignoreHold && s.holdT >= bd_pkg::PRESS_MIN_T && s.holdT < bd_pkg::PRESS_MAX_T;
      next_s.ignoreHold = 1'b0;
      next_s.holdT = '0;
    end
    case (s.st)
      bd_pkg::IDLE: begin
        if (press && !vehicleMoving) begin
          next_s.st = bd_pkg::COUNT;
          next_s.presses = 4'h1;
          next_s.gapT = '0;
          next_s.inTest = 1'b0;
        end
      end
      bd_pkg::TEST: begin
        if (press) begin
          next_s.st = bd_pkg::COUNT;
          next_s.presses = 4'h1;
          next_s.gapT = '0;
          next_s.inTest = 1'b1;
        end
      end
      bd_pkg::COUNT: begin
        if (vehicleMoving) begin
          next_s.st = s.inTest ? bd_pkg::TEST : bd_pkg::IDLE;
        end else if (press) begin
          // a late press opens a fresh sequence
          if (s.gapT > bd_pkg::GAP_T) next_s.presses = 4'h1;
          else if (s.presses != 4'hF) next_s.presses = s.presses + 1'b1;
          next_s.gapT = '0;
        end else if (s.tick && !s.swLevel && !s.prevLevel) begin
          next_s.gapT = s.gapT + 1'b1;
          if (next_s.gapT == bd_pkg::RESP_T) next_s = dispatch(next_s);
        end
      end
      bd_pkg::BLINK: begin
        // switch activity is ignored until the message ends
        found = nextFrom(msgMask(s), {1'b0, s.msgIdx} + 5'h01);
        if (vehicleMoving) begin
          next_s.st = bd_pkg::IDLE;
        end else if (s.tick) begin
          next_s.blT = s.blT + 1'b1;
          case (s.ph)
            bd_pkg::PH_ON: begin
              if (s.blT == bd_pkg::BLINK_T - 1'b1) begin
                next_s.lamp = 1'b0;
                next_s.blT = '0;
                next_s.blinkLeft = s.blinkLeft - 1'b1;
                next_s.ph = bd_pkg::PH_GAP;
                if (s.blinkLeft != 4'h1) next_s.gapLim = bd_pkg::BLINK_T;
                else if (!lastDigit(s)) next_s.gapLim = bd_pkg::DIGIT_T;
                else next_s.gapLim = bd_pkg::MSG_T;
              end
            end
            bd_pkg::PH_GAP: begin
              if (s.blT == s.gapLim - 1'b1) begin
                if (s.blinkLeft != 4'h0) begin
                  next_s.lamp = 1'b1;
                  next_s.ph = bd_pkg::PH_ON;
                  next_s.blT = '0;
                end else if (!lastDigit(s)) begin
                  next_s.digSel = s.digSel + 1'b1;
                  next_s = loadDigit(next_s);
                end else if (found[4] && s.src != bd_pkg::SRC_CONFIG) begin
                  next_s.msgIdx = found[3:0];
                  next_s.digSel = '0;
                  next_s = loadDigit(next_s);
                end else begin
                  // steady-on follows a message gap so the last blink stays countable
                  next_s.ph = bd_pkg::PH_FINAL;
                  next_s.blT = '0;
                  next_s.lamp = 1'b1;
                end
              end
            end
            default: begin
              if (s.blT == bd_pkg::FINAL_T - 1'b1) next_s.st = bd_pkg::IDLE;
            end
          endcase
        end
      end
      default: next_s.st = bd_pkg::IDLE;
    endcase
    if (next_s.wssHold && wheelSpeedValid) begin
      if (next_s.act[0].valid) next_s = histPush(next_s, 1'b0, next_s.act[0].code);
      next_s.act[0].valid = 1'b0;
      next_s.wssHold = 1'b0;
    end
    if (next_s.st != bd_pkg::BLINK) begin
      next_s.lamp = next_s.st == bd_pkg::TEST;
      for (int i = 0; i < bd_pkg::N_ACT; i++) next_s.lamp = next_s.lamp | next_s.act[i].valid;
      // dark while counting so the first blink of the answer is seen
      if (next_s.st == bd_pkg::COUNT) next_s.lamp = 1'b0;
    end
    next_s.spinEn = (next_s.setup[bd_pkg::CFG_ENG] | next_s.setup[bd_pkg::CFG_BRK]) & ~next_s.testStand;
    next_s.wssOut = '0;
    for (int i = 0; i < bd_pkg::N_ACT; i++) begin
      if (next_s.act[i].valid && next_s.act[i].wss) next_s.wssOut = next_s.act[i].code;
    end
    // read data is taken in the setup cycle so the access phase needs no wait
    if (apbReq.psel && !apbReq.penable) begin
      next_s.slvErr = 1'b0;
      next_s.rdata = '0;
      if (apbReq.paddr == bd_pkg::ADDR_CTRL) begin
        next_s.rdata = 32'(s.testStand);
      end else if (apbReq.paddr == bd_pkg::ADDR_CONFIG) begin
        next_s.rdata = 32'(s.setup);
      end else if (apbReq.paddr == bd_pkg::ADDR_FAULT) begin
        for (int i = 0; i < bd_pkg::N_ACT; i++) next_s.rdata[i] = s.act[i].valid;
      end else if (apbReq.paddr == bd_pkg::ADDR_NOTE) begin
        next_s.rdata = '0;
      end else if (apbReq.paddr == bd_pkg::ADDR_STATUS) begin
        next_s.rdata = 32'({s.histCnt, s.wssHold, s.testStand, s.reconfigReq, s.switchFault, s.lamp, s.st});
      end else if (apbReq.paddr == bd_pkg::ADDR_HIST) begin
        next_s.rdata = 32'({s.histIdx, {1'b0, s.histIdx} < s.histCnt, s.hist[s.histIdx]});
      end else begin
        next_s.slvErr = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s <= bd_pkg::RESET_REGS;
    end else begin
      s <= next_s;
    end
  end

  assign lamp = s.lamp;
  assign wheelSpinEnable = s.spinEn;
  assign testStandMode = s.testStand;
  assign retainedWssOut = s.wssOut;
  assign reconfigStart = s.reconfigStart;
  assign apbRsp = '{prdata: s.rdata, pready: 1'b1, pslverr: s.slvErr};

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence dispatchSeq;
    s.st == bd_pkg::COUNT && !s.inTest && s.tick && !s.swLevel && !s.prevLevel &&
      s.gapT == bd_pkg::RESP_T - 1'b1 && !vehicleMoving;
  endsequence

  active_blink_a: assert property (
    dispatchSeq and s.presses == 4'h1 |=> s.st == bd_pkg::BLINK && s.src == bd_pkg::SRC_ACTIVE)
    else $error("one press did not start active code display");
  hist_blink_a: assert property (
    dispatchSeq and s.presses == 4'h2 |=> s.st == bd_pkg::BLINK && s.src == bd_pkg::SRC_HIST)
    else $error("two presses did not start history display");
  clear_all_a: assert property (
    dispatchSeq and s.presses == 4'h3 |=> s.act[0].valid == 1'b0 && s.st == bd_pkg::IDLE)
    else $error("three presses did not clear active faults");
  config_blink_a: assert property (
    dispatchSeq and s.presses == 4'h4 |=> s.st == bd_pkg::BLINK && s.src == bd_pkg::SRC_CONFIG && s.lamp)
    else $error("four presses did not start configuration report");
  test_entry_a: assert property (
    dispatchSeq and s.presses == 4'h5 |=> s.testStand ##1 !wheelSpinEnable)
    else $error("five presses did not enter test stand");
  reconfig_a: assert property (
    dispatchSeq and s.presses == 4'h7 |=> s.reconfigStart == $past(s.armed) ##1 !s.reconfigStart)
    else $error("reconfiguration pulse wrong");
  wss_hold_a: assert property (
    s.wssHold && wheelSpeedValid |=> !s.wssHold && !s.act[0].valid)
    else $error("sensor fault not released on valid speed");
  config_six_a: assert property (
    s.st == bd_pkg::BLINK && s.src == bd_pkg::SRC_CONFIG |-> s.digSel <= bd_pkg::CFG_LAST)
    else $error("configuration report exceeds six digits");
  short_press_a: assert property (
    s.st == bd_pkg::IDLE && s.prevLevel && !s.swLevel && s.holdT < bd_pkg::PRESS_MIN_T |=> s.st == bd_pkg::IDLE)
    else $error("short press was counted");
  motion_exit_a: assert property (
    s.st == bd_pkg::BLINK && vehicleMoving |=> s.st == bd_pkg::IDLE)
    else $error("blink mode kept during motion");
endmodule

// ==== tb/tech_switch.sv ====
module tech_switch #(
  parameter int TICK = 4
) (
  // clock and lamp seen by the technician
  input  wire logic sys_clk,
  input  wire logic lamp,
  // switch pin and lamp pulse count
  output logic      blinkSwitch,
  output int        lampEdges
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prevLamp;
  initial begin
    blinkSwitch = 1'b0;
    lampEdges   = 0;
    prevLamp    = 1'b0;
  end
  // every blink and the final steady-on period each give one rising edge
  always @(posedge sys_clk) begin
    prevLamp <= lamp;
    if (lamp === 1'b1 && prevLamp === 1'b0) begin
      lampEdges <= lampEdges + 1;
    end
  end
  // closed for holdTicks, then open 30 ticks so presses stay in one sequence
  task automatic press(input int n, input int holdTicks);
    repeat (n) begin
      @(posedge sys_clk);
      blinkSwitch <= 1'b1;
      repeat (holdTicks * TICK) @(posedge sys_clk);
      blinkSwitch <= 1'b0;
      repeat (30 * TICK) @(posedge sys_clk);
    end
  endtask
  // used to hold the switch across ignition power-up
  task automatic level(input logic v);
    @(posedge sys_clk);
    blinkSwitch <= v;
  endtask
  task automatic clear();
    @(posedge sys_clk);
    lampEdges <= 0;
  endtask
endmodule

// ==== tb/blink_code_diag_bench.sv ====
module blink_code_diag_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 4;
  localparam int CFG[3]   = '{'h00, 'h07, 'hFF};
  localparam int EDGES[3] = '{14, 20, 25};
  logic                sys_clk, reset, vehicleMoving, wheelSpeedValid, storedTestStand;
  logic [7:0]          retainedWss, retainedWssOut;
  logic                blinkSwitch, lamp, wheelSpinEnable, testStandMode, reconfigStart;
  bd_pkg::apb_req_type apbReq;
  bd_pkg::apb_rsp_type apbRsp;
  logic [31:0]         rd;
  logic                err;
  int                  num_errors, tests_run, lampEdges, reconfigs;

  blink_code_diag #(.TICK_CYCLES(TICK)) i_blink_code_diag (.sys_clk(sys_clk), .reset(reset),
    .blinkSwitch(blinkSwitch), .vehicleMoving(vehicleMoving), .wheelSpeedValid(wheelSpeedValid),
    .storedTestStand(storedTestStand), .retainedWss(retainedWss), .lamp(lamp), .wheelSpinEnable(wheelSpinEnable),
    .testStandMode(testStandMode), .retainedWssOut(retainedWssOut), .reconfigStart(reconfigStart),
    .apbReq(apbReq), .apbRsp(apbRsp));
  tech_switch #(.TICK(TICK)) i_tech_switch (.sys_clk(sys_clk), .lamp(lamp), .blinkSwitch(blinkSwitch),
    .lampEdges(lampEdges));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (reconfigStart === 1'b1) reconfigs <= reconfigs + 1;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // request held until pready is sampled high; read data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    do @(posedge sys_clk); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask
  task automatic power(input logic [7:0] wss, input logic stand);
    @(posedge sys_clk);
    reset <= 1'b1;
    retainedWss <= wss;
    storedTestStand <= stand;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  // polls status until idle or test stand; a negative count skips the lamp check
  task automatic run(input int n, input int exp, input string name);
    i_tech_switch.clear();
    i_tech_switch.press(n, 15);
    for (int i = 0; i < 300; i++) begin
      repeat (100) @(posedge sys_clk);
      apb(1'b0, bd_pkg::ADDR_STATUS, 32'h0);
      if (rd[2:0] == 3'h0 || rd[2:0] == 3'h3) break;
    end
    if (exp >= 0) chk(name, lampEdges, exp);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // the whole sequence needs about 80000 cycles
  initial begin
    repeat (95000) @(posedge sys_clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    reset = 1'b1;
    vehicleMoving = 1'b0;
    wheelSpeedValid = 1'b0;
    storedTestStand = 1'b0;
    retainedWss = 8'h00;
    apbReq = '0;
    num_errors = 0;
    tests_run = 0;
    reconfigs = 0;
    power(8'h25, 1'b0);
    apb(1'b0, bd_pkg::ADDR_FAULT, 32'h0);
    chk("sensor hold", rd, 32'h1);
    chk("sensor out", retainedWssOut, 32'h25);
    apb(1'b1, bd_pkg::ADDR_CTRL, 32'h2);
    apb(1'b0, bd_pkg::ADDR_FAULT, 32'h0);
    chk("tool clear", rd, 32'h0);
    apb(1'b0, bd_pkg::ADDR_STATUS, 32'h0);
    chk("history count", rd[12:8], 32'h1);
    apb(1'b1, bd_pkg::ADDR_CTRL, 32'h4);
    apb(1'b0, bd_pkg::ADDR_STATUS, 32'h0);
    chk("history erase", rd[12:8], 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("bad address", {err, rd[0]}, 32'h2);
    apb(1'b1, bd_pkg::ADDR_FAULT, 32'h21);
    apb(1'b1, bd_pkg::ADDR_FAULT, 32'h12);
    run(1, 7, "active blinks");
    run(3, -1, "");
    apb(1'b0, bd_pkg::ADDR_FAULT, 32'h0);
    chk("switch clear", rd, 32'h0);
    apb(1'b1, bd_pkg::ADDR_NOTE, 32'h35);
    apb(1'b1, bd_pkg::ADDR_HIST, 32'h0);
    apb(1'b0, bd_pkg::ADDR_HIST, 32'h0);
    chk("history fault", rd, 32'h221);
    apb(1'b1, bd_pkg::ADDR_HIST, 32'h2);
    apb(1'b0, bd_pkg::ADDR_HIST, 32'h0);
    chk("history note", rd, 32'hB35);
    run(2, 7, "history blinks");
    foreach (CFG[i]) begin
      apb(1'b1, bd_pkg::ADDR_CONFIG, CFG[i]);
      run(4, EDGES[i], "config blinks");
    end
    run(6, 0, "six presses");
    run(7, 0, "seven presses");
    chk("no reconfig", reconfigs, 32'h0);
    vehicleMoving <= 1'b1;
    run(1, 0, "moving");
    vehicleMoving <= 1'b0;
    run(5, -1, "");
    chk("test stand", {testStandMode, wheelSpinEnable}, 32'h2);
    power(8'h00, testStandMode);
    chk("stand kept", testStandMode, 32'h1);
    run(3, -1, "");
    chk("leave test", {rd[6], rd[2:0]}, 32'h8);
    apb(1'b1, bd_pkg::ADDR_CTRL, 32'h0);
    apb(1'b0, bd_pkg::ADDR_CTRL, 32'h0);
    chk("tool stand off", {rd[0], testStandMode}, 32'h0);
    i_tech_switch.press(1, 600);
    apb(1'b0, bd_pkg::ADDR_STATUS, 32'h0);
    chk("switch fault", rd[4], 32'h1);
    apb(1'b1, bd_pkg::ADDR_FAULT, 32'h21);
    i_tech_switch.level(1'b1);
    power(8'h00, 1'b0);
    repeat (40 * TICK) @(posedge sys_clk);
    i_tech_switch.level(1'b0);
    repeat (40 * TICK) @(posedge sys_clk);
    apb(1'b0, bd_pkg::ADDR_FAULT, 32'h0);
    chk("power clear", rd, 32'h0);
    run(7, -1, "");
    chk("reconfig", reconfigs, 32'h1);
    power(8'h25, 1'b0);
    wheelSpeedValid <= 1'b1;
    apb(1'b0, bd_pkg::ADDR_STATUS, 32'h0);
    chk("speed release", {rd[12:7], retainedWssOut}, 32'h200);
    end_of_test();
  end
endmodule
